// >>> hw/sec_comp_rom.sv
`timescale 1ns/10ps
`default_nettype none
module sec_comp_rom (
  input  wire sec_pkg::sec_kind_t      kind,
  input  wire logic [2:0]              idx,
  input  wire sec_pkg::sec_burst_cfg_t cfg,
  output logic [7:0]                   byte_out
);
  import sec_pkg::*;

  logic        bulk;
  logic [7:0]  burst;
  logic [15:0] ivl;

  // every byte is fixed or a burst field, nothing from nonvolatile store
  always_comb begin
    bulk  = (kind != SEC_INTR);
    ivl   = bulk ? SEC_BULK_INTERVAL : SEC_INTR_INTERVAL;
    unique case (kind)
      SEC_BULK_IN:  burst = sec_clamp_burst(cfg.bulk_in_burst_limit);
      SEC_BULK_OUT: burst = cfg.bulk_out_burst_ovr ?
                            sec_clamp_burst(cfg.bulk_out_burst_limit) : SEC_BURST_DEFAULT;
      default:      burst = SEC_INTR_BURST;
    endcase
    unique case (idx)
      SEC_OFS_LEN:   byte_out = SEC_COMP_LEN;
      SEC_OFS_TYPE:  byte_out = SEC_COMP_TYPE;
      SEC_OFS_BURST: byte_out = burst;
      SEC_OFS_ATTR:  byte_out = bulk ? SEC_BULK_ATTR : SEC_INTR_ATTR;
      SEC_OFS_IVL_L: byte_out = ivl[7:0];
      SEC_OFS_IVL_H: byte_out = ivl[15:8];
      default:       byte_out = 8'h00;
    endcase
  end

endmodule
`default_nettype wire

// >>> hw/sec_pkg.sv
package sec_pkg;

  // descriptor framing
  localparam logic [7:0] SEC_COMP_LEN       = 8'h06;
  localparam logic [7:0] SEC_COMP_TYPE      = 8'h30;
  localparam logic [7:0] SEC_EP_DESC_TYPE   = 8'h05;
  localparam logic [7:0] SEC_BURST_DEFAULT  = 8'h03;
  localparam logic [7:0] SEC_BURST_MAX      = 8'h0F;
  localparam logic [7:0] SEC_BULK_ATTR      = 8'h00;
  localparam logic [7:0] SEC_INTR_BURST     = 8'h00;
  localparam logic [7:0] SEC_INTR_ATTR      = 8'h00;
  localparam logic [15:0] SEC_BULK_INTERVAL = 16'h0000;
  localparam logic [15:0] SEC_INTR_INTERVAL = 16'h0004;

  // byte offsets inside a companion descriptor
  localparam logic [2:0] SEC_OFS_LEN   = 3'h0;
  localparam logic [2:0] SEC_OFS_TYPE  = 3'h1;
  localparam logic [2:0] SEC_OFS_BURST = 3'h2;
  localparam logic [2:0] SEC_OFS_ATTR  = 3'h3;
  localparam logic [2:0] SEC_OFS_IVL_L = 3'h4;
  localparam logic [2:0] SEC_OFS_IVL_H = 3'h5;

  // byte offsets inside an endpoint descriptor
  localparam logic [7:0] SEC_EP_OFS_LEN  = 8'h00;
  localparam logic [7:0] SEC_EP_OFS_TYPE = 8'h01;
  localparam logic [7:0] SEC_EP_OFS_ADDR = 8'h02;
  localparam logic [7:0] SEC_EP_OFS_ATTR = 8'h03;
  localparam int unsigned SEC_EP_DIR_BIT = 7;
  localparam logic [1:0] SEC_XFER_BULK   = 2'h2;
  localparam logic [1:0] SEC_XFER_INTR   = 2'h3;

  typedef enum logic [1:0] {SEC_BULK_IN, SEC_BULK_OUT, SEC_INTR} sec_kind_t;
  typedef enum logic {SEC_PASS, SEC_COMP} sec_mode_t;

  // burst-size fields of usb_config_word_zero
  typedef struct packed {
    logic [7:0] bulk_in_burst_limit;
    logic [7:0] bulk_out_burst_limit;
    logic       bulk_out_burst_ovr;
  } sec_burst_cfg_t;

  // one byte of descriptor data with its end marker
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } sec_byte_t;

  typedef struct packed {
    sec_mode_t  mode;
    logic       in_ready;
    logic       out_valid;
    sec_byte_t  out;
    logic       out_comp;
    logic [2:0] out_cidx;
    sec_kind_t  out_kind;
    logic [7:0] pos;
    logic [7:0] dlen;
    logic [7:0] dtype;
    logic       ep_dir;
    logic [1:0] ep_xfer;
    sec_kind_t  kind;
    logic [2:0] cidx;
    logic       last_pend;
  } sec_state_t;

  // burst byte never exceeds sixteen packets
  function automatic logic [7:0] sec_clamp_burst(input logic [7:0] v);
    sec_clamp_burst = (v > SEC_BURST_MAX) ? SEC_BURST_MAX : v;
  endfunction

endpackage

// >>> hw/sec_splicer.sv
`timescale 1ns/10ps
`default_nettype none
module sec_splicer (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   ss_mode,
  input  wire sec_pkg::sec_burst_cfg_t burst_cfg,
  input  wire logic                   in_valid,
  input  wire sec_pkg::sec_byte_t     in_byte,
  output logic                        in_ready,
  output logic                        out_valid,
  output sec_pkg::sec_byte_t          out_byte,
  input  wire logic                   out_ready
);
  import sec_pkg::*;

  sec_state_t s_r;
  sec_state_t s_nxt;
  logic [7:0] rom_byte;
  logic       take;
  logic       free;
  logic       ep_end;
  logic       has_comp;
  sec_kind_t  new_kind;

  // companion bytes for the endpoint being extended, fixed except the burst byte from burst_cfg
  sec_comp_rom u_rom (
    .kind     (s_r.kind),
    .idx      (s_r.cidx),
    .cfg      (burst_cfg),
    .byte_out (rom_byte)
  );

  // endpoint kind from direction and transfer type; control/iso get no companion
  always_comb begin
    has_comp = 1'b1;
    new_kind = SEC_INTR;
    if (s_r.ep_xfer == SEC_XFER_BULK) begin
      new_kind = s_r.ep_dir ? SEC_BULK_IN : SEC_BULK_OUT;
    end else if (s_r.ep_xfer != SEC_XFER_INTR) begin
      has_comp = 1'b0;
    end
  end

  // one-byte output slot: half throughput, but no buffer and flopped ready
  always_comb begin
    s_nxt  = s_r;
    take   = in_valid && s_r.in_ready;
    free   = !s_r.out_valid || out_ready;
    ep_end = 1'b0;
    if (s_r.out_valid && out_ready) begin
      s_nxt.out_valid = 1'b0;
    end
    unique case (s_r.mode)
      SEC_PASS: begin
        if (take) begin
          s_nxt.out_valid = 1'b1;
          s_nxt.out       = in_byte;
          s_nxt.out_comp  = 1'b0;
          // capture the header fields that decide whether a companion follows
          if (s_r.pos == SEC_EP_OFS_LEN) s_nxt.dlen = in_byte.data;
          if (s_r.pos == SEC_EP_OFS_TYPE) s_nxt.dtype = in_byte.data;
          if (s_r.pos == SEC_EP_OFS_ADDR) s_nxt.ep_dir = in_byte.data[SEC_EP_DIR_BIT];
          if (s_r.pos == SEC_EP_OFS_ATTR) s_nxt.ep_xfer = in_byte.data[1:0];
          // a zero length byte is treated as a one-byte descriptor to avoid a stall
          if (s_r.pos + 8'h01 >= ((s_r.pos == SEC_EP_OFS_LEN) ? in_byte.data : s_r.dlen)) begin
            s_nxt.pos = SEC_EP_OFS_LEN;
            ep_end    = (s_r.dtype == SEC_EP_DESC_TYPE) && (s_r.pos > SEC_EP_OFS_TYPE);
          end else begin
            s_nxt.pos = s_r.pos + 8'h01;
          end
          // end marker moves on to the companion's last byte
          if (ep_end && ss_mode && has_comp) begin
            s_nxt.mode      = SEC_COMP;
            s_nxt.kind      = new_kind;
            s_nxt.cidx      = SEC_OFS_LEN;
            s_nxt.last_pend = in_byte.last;
            s_nxt.out.last  = 1'b0;
          end
        end
      end
      SEC_COMP: begin
        // one companion byte per free slot, taken from the table (burst byte from burst_cfg)
        if (free) begin
          s_nxt.out_valid = 1'b1;
          s_nxt.out.data  = rom_byte;
          s_nxt.out_comp  = 1'b1;
          s_nxt.out_cidx  = s_r.cidx;
          s_nxt.out_kind  = s_r.kind;
          s_nxt.out.last  = (s_r.cidx == SEC_OFS_IVL_H) && s_r.last_pend;
          if (s_r.cidx == SEC_OFS_IVL_H) begin
            s_nxt.mode = SEC_PASS;
          end else begin
            s_nxt.cidx = s_r.cidx + 3'h1;
          end
        end
      end
    endcase
    // ready only with an empty slot in pass mode, never mid-companion
    s_nxt.in_ready = (s_nxt.mode == SEC_PASS) && !s_nxt.out_valid;
  end

  // state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign in_ready  = s_r.in_ready;
  assign out_valid = s_r.out_valid;
  assign out_byte  = s_r.out;

  // checks on the emitted companion bytes
  logic comp_out;
  logic comp_start;
  assign comp_out = s_r.out_valid && s_r.out_comp;

  // endpoint's last byte taken and a companion will follow it
  assign comp_start = take && ss_mode && has_comp && ep_end;

  sequence ep_last_taken;
    take && ss_mode && has_comp && ep_end;
  endsequence

  sequence comp_runs;
    (s_r.mode == SEC_COMP) ##[1:30] (s_r.mode == SEC_PASS);
  endsequence

  a_comp_length: assert property (@(posedge ref_clk) disable iff (!rst_n)
    comp_out && s_r.out_cidx == SEC_OFS_LEN |-> s_r.out.data == SEC_COMP_LEN)
    else $error("companion length byte wrong");
  a_comp_type: assert property (@(posedge ref_clk) disable iff (!rst_n)
    comp_out && s_r.out_cidx == SEC_OFS_TYPE |-> s_r.out.data == SEC_COMP_TYPE)
    else $error("companion type byte wrong");
  a_bulk_in_burst: assert property (@(posedge ref_clk) disable iff (!rst_n)
    comp_out && s_r.out_cidx == SEC_OFS_BURST && s_r.out_kind == SEC_BULK_IN
    && $past(s_r.cidx) == SEC_OFS_BURST
    |-> s_r.out.data == sec_clamp_burst($past(burst_cfg.bulk_in_burst_limit)))
    else $error("bulk-in burst not from config field");
  a_bulk_out_burst: assert property (@(posedge ref_clk) disable iff (!rst_n)
    comp_out && s_r.out_cidx == SEC_OFS_BURST && s_r.out_kind == SEC_BULK_OUT
    && $past(s_r.cidx) == SEC_OFS_BURST
    |-> s_r.out.data == ($past(burst_cfg.bulk_out_burst_ovr) ?
        sec_clamp_burst($past(burst_cfg.bulk_out_burst_limit)) : SEC_BURST_DEFAULT))
    else $error("bulk-out burst byte wrong");
  a_burst_legal: assert property (@(posedge ref_clk) disable iff (!rst_n)
    comp_out && s_r.out_cidx == SEC_OFS_BURST |-> s_r.out.data <= SEC_BURST_MAX)
    else $error("burst byte above fifteen");
  a_bulk_attr_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    comp_out && s_r.out_kind != SEC_INTR && s_r.out_cidx == SEC_OFS_ATTR
    |-> s_r.out.data == SEC_BULK_ATTR)
    else $error("bulk attributes not zero");
  a_bulk_ivl_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    comp_out && s_r.out_kind != SEC_INTR && s_r.out_cidx >= SEC_OFS_IVL_L
    |-> s_r.out.data == 8'h00)
    else $error("bulk interval not zero");
  a_intr_fields: assert property (@(posedge ref_clk) disable iff (!rst_n)
    comp_out && s_r.out_kind == SEC_INTR && s_r.out_cidx >= SEC_OFS_BURST
    |-> s_r.out.data == ((s_r.out_cidx == SEC_OFS_BURST) ? SEC_INTR_BURST :
                         (s_r.out_cidx == SEC_OFS_ATTR) ? SEC_INTR_ATTR :
                         (s_r.out_cidx == SEC_OFS_IVL_L) ? SEC_INTR_INTERVAL[7:0] :
                         SEC_INTR_INTERVAL[15:8]))
    else $error("interrupt companion fields wrong");
  a_comp_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ep_last_taken |=> comp_runs)
    else $error("companion did not follow endpoint descriptor");

  // companion starts at once and runs in order with upstream held off
  a_comp_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
    comp_start |=> s_r.mode == SEC_COMP && s_r.cidx == SEC_OFS_LEN && !s_r.out.last)
    else $error("companion not started after endpoint descriptor");
  a_in_held_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.mode == SEC_COMP |-> !s_r.in_ready)
    else $error("upstream byte accepted inside a companion");
  a_cidx_range: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.mode == SEC_COMP |-> s_r.cidx <= SEC_OFS_IVL_H)
    else $error("companion index beyond sixth byte");
  a_comp_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.mode == SEC_COMP && (!s_r.out_valid || out_ready)
    |=> comp_out && s_r.out_cidx == $past(s_r.cidx) && s_r.out_kind == $past(s_r.kind))
    else $error("companion bytes out of order");

  // no companion off SuperSpeed or for control and isochronous endpoints
  a_no_comp_slow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && ep_end && !ss_mode |=> s_r.mode == SEC_PASS)
    else $error("companion inserted below SuperSpeed");
  a_other_no_comp: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && ep_end && s_r.ep_xfer != SEC_XFER_BULK && s_r.ep_xfer != SEC_XFER_INTR
    |=> s_r.mode == SEC_PASS)
    else $error("companion inserted for control or isochronous endpoint");
  a_last_moved: assert property (@(posedge ref_clk) disable iff (!rst_n)
    comp_out && s_r.out_cidx != SEC_OFS_IVL_H |-> !s_r.out.last)
    else $error("end marker inside a companion");

  // a byte on offer stands unchanged until the host takes it
  a_out_stands: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.out_valid && !out_ready |=> s_r.out_valid && $stable(s_r.out))
    else $error("output byte changed before it was taken");

  // companion kind follows the endpoint's direction and transfer type
  a_kind_bulk_in: assert property (@(posedge ref_clk) disable iff (!rst_n)
    comp_start && s_r.ep_xfer == SEC_XFER_BULK && s_r.ep_dir |=> s_r.kind == SEC_BULK_IN)
    else $error("bulk-in endpoint given wrong companion");
  a_kind_bulk_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
    comp_start && s_r.ep_xfer == SEC_XFER_BULK && !s_r.ep_dir |=> s_r.kind == SEC_BULK_OUT)
    else $error("bulk-out endpoint given wrong companion");
  a_kind_intr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    comp_start && s_r.ep_xfer == SEC_XFER_INTR |=> s_r.kind == SEC_INTR)
    else $error("interrupt endpoint given wrong companion");

endmodule
`default_nettype wire

// >>> test/sec_host_sink.sv
`timescale 1ns/10ps
`default_nettype none
// host-side reader of the descriptor stream; slow mode stalls at random
module sec_host_sink (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               slow,
  input  wire logic               out_valid,
  input  wire sec_pkg::sec_byte_t out_byte,
  output logic                    out_ready
);
  import sec_pkg::*;
  sec_byte_t rx_q[$];

  // take on the sampling edge, move ready only just after it
  initial out_ready = 1'b0;
  always @(posedge ref_clk) begin
    if (rst_n && out_valid && out_ready) rx_q.push_back(out_byte);
    #10 out_ready = rst_n && (!slow || ($urandom_range(0, 2) != 0));
  end
endmodule
`default_nettype wire

// >>> test/test_ss_endpoint_companion_descriptors.sv
`timescale 1ns/10ps
`default_nettype none
module test_ss_endpoint_companion_descriptors;
  import sec_pkg::*;
  logic           ref_clk;
  logic           rst_n;
  logic           ss_mode;
  logic           slow;
  sec_burst_cfg_t burst_cfg;
  logic           in_valid;
  sec_byte_t      in_byte;
  logic           in_ready;
  logic           out_valid;
  sec_byte_t      out_byte;
  logic           out_ready;
  int             fail_count;
  int             checks_done;
  sec_byte_t      in_q[$];
  sec_byte_t      exp_q[$];
  bit             isb_q[$];

  sec_splicer i_sec_splicer (.ref_clk(ref_clk), .rst_n(rst_n), .ss_mode(ss_mode),
    .burst_cfg(burst_cfg), .in_valid(in_valid), .in_byte(in_byte), .in_ready(in_ready),
    .out_valid(out_valid), .out_byte(out_byte), .out_ready(out_ready));
  sec_host_sink i_sec_host_sink (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow),
    .out_valid(out_valid), .out_byte(out_byte), .out_ready(out_ready));

  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // burst byte as the host should see it: clamped at sixteen packets
  function automatic logic [7:0] exp_burst(input logic dir, input logic [1:0] xf);
    logic [7:0] v;
    v = dir ? burst_cfg.bulk_in_burst_limit : burst_cfg.bulk_out_burst_limit;
    if (xf == 2'h3) return 8'h00;
    if (!dir && !burst_cfg.bulk_out_burst_ovr) return 8'h03;
    return (v > 8'h0F) ? 8'h0F : v;
  endfunction

  // endpoint descriptor with noise in its tail; companion expected after it only for bulk and interrupt in SuperSpeed mode
  task automatic add_ep(input logic dir, input logic [1:0] xf, input logic lst);
    logic [7:0] b [7];
    bit         comp;
    comp = ss_mode && xf[1];
    b = '{8'h07, 8'h05, {dir, 3'h0, 4'($urandom_range(1, 15))}, {6'h00, xf},
          8'($urandom), 8'($urandom), 8'($urandom)};
    for (int i = 0; i < 7; i++) begin
      in_q.push_back(sec_byte_t'{b[i], lst && i == 6});
      exp_q.push_back(sec_byte_t'{b[i], lst && i == 6 && !comp});
      isb_q.push_back(1'b0);
    end
    if (comp) begin
      b = '{8'h06, 8'h30, exp_burst(dir, xf), 8'h00, xf[0] ? 8'h04 : 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 6; i++) begin
        exp_q.push_back(sec_byte_t'{b[i], lst && i == 5});
        isb_q.push_back(i == 2);
      end
    end
  endtask

  // request held until the edge that samples in_ready high
  task automatic send_all();
    foreach (in_q[i]) begin
      in_valid = 1'b1;
      in_byte = in_q[i];
      @(posedge ref_clk);
      for (int n = 0; n < 60 && in_ready !== 1'b1; n++) @(posedge ref_clk);
      chk(9'(in_ready), 9'h001);
      #10;
    end
    in_valid = 1'b0;
    in_byte = sec_byte_t'{8'($urandom), 1'b0};
  endtask

  initial begin
    sec_byte_t got;
    rst_n = 1'b0;
    ss_mode = 1'b1;
    slow = 1'b0;
    burst_cfg = '0;
    in_valid = 1'b0;
    in_byte = '0;
    fail_count = 0;
    checks_done = 0;
    void'($urandom(20));
    repeat (12) @(posedge ref_clk);
    #10 rst_n = 1'b1;
    for (int t = 0; t < 8; t++) begin
      @(posedge ref_clk);
      #10;
      burst_cfg = '{8'($urandom_range(0, 40)), 8'($urandom_range(0, 40)), 1'($urandom)};
      if (t == 0) burst_cfg = '{8'h00, 8'h0F, 1'b1}; // one and sixteen packets
      if (t == 1) burst_cfg = '{8'hFF, 8'h10, 1'b1}; // beyond range, must clamp
      if (t == 2) burst_cfg = '{8'h0F, 8'hFF, 1'b0}; // override off
      ss_mode = (t != 3);
      slow = t[0];
      in_q.delete();
      exp_q.delete();
      isb_q.delete();
      i_sec_host_sink.rx_q.delete();
      // configuration header passes untouched, iso and control endpoints get no companion
      for (int i = 0; i < 9; i++) begin
        got = sec_byte_t'{i == 0 ? 8'h09 : (i == 1 ? 8'h02 : 8'($urandom)), 1'b0};
        in_q.push_back(got);
        exp_q.push_back(got);
        isb_q.push_back(1'b0);
      end
      add_ep(1'b0, 2'h1, 1'b0);
      add_ep(1'b1, 2'h0, 1'b0);
      add_ep(1'b1, 2'h2, 1'b0);
      add_ep(1'b0, 2'h2, 1'b0);
      add_ep(1'b1, 2'h3, 1'b1);
      send_all();
      for (int n = 0; n < 400 && i_sec_host_sink.rx_q.size() < exp_q.size(); n++)
        @(posedge ref_clk);
      chk(9'(i_sec_host_sink.rx_q.size()), 9'(exp_q.size()));
      foreach (exp_q[i]) begin
        got = (i < i_sec_host_sink.rx_q.size()) ? i_sec_host_sink.rx_q[i] : 'x;
        if (isb_q[i]) chk(got, exp_q[i]);
        else chk(got, exp_q[i]);
      end
      $display("test %0d done ss=%0b cfg=%h", t, ss_mode, burst_cfg);
    end
    finish_test();
  end

  // hang guard, well past eight streams with stalls
  initial begin
    #(20000 * 100);
    fail_count++;
    $display("ERROR t=%0t watchdog expired", $time);
    finish_test();
  end
endmodule
`default_nettype wire
